// ==== core/fieldbus_io_pkg.sv ====
// Constants and carrier types for the fieldbus cyclic word map
package fieldbus_io_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int WORD_W = 16;
   localparam int PNUM_W = 11;
   localparam int IDX_W  = 4;

   typedef logic [WORD_W-1:0] word_t;
   typedef logic [PNUM_W-1:0] pnum_t;
   typedef logic [IDX_W-1:0]  idx_t;

   // ----------------------------------------
   // Parameter numbers
   // ----------------------------------------
   localparam pnum_t RD_MAP_FIRST   = 11'h2c7;
   localparam pnum_t WR_MAP_FIRST   = 11'h2d3;
   localparam pnum_t CMD_WORD_NUM   = 11'h2df;
   localparam pnum_t STATE_WORD_NUM = 11'h2e0;
   localparam word_t PTR_MAX        = 16'h04e1;
   localparam int    MAP_SLOTS      = 12;

   // ----------------------------------------
   // Word positions and size options
   // ----------------------------------------
   localparam idx_t WORD_CMD      = 4'h1;
   localparam idx_t WORD_REF      = 4'h2;
   localparam idx_t WORD_MAP_MIN  = 4'h3;
   localparam idx_t WORD_MAP_MAX  = 4'he;
   localparam idx_t IO_SIZE_MIN   = 4'h3;
   localparam idx_t IO_SIZE_MAX   = 4'hf;
   localparam idx_t MAX_WORDS     = 4'he;

   // ----------------------------------------
   // Command and state word fields
   // ----------------------------------------
   localparam int CW_ENABLE_BIT    = 0;
   localparam int CW_STOP_BIT      = 1;
   localparam int CW_DIR_BIT       = 2;
   localparam int CW_DRV_RESET_BIT = 6;
   localparam int CW_FLT_RESET_BIT = 7;
   localparam int MODE_LSB         = 8;
   localparam int MODE_MSB         = 10;
   localparam int SW_REACHED_BIT   = 6;
   localparam int SW_FAULT_BIT     = 7;

   localparam logic [2:0] MODE_TORQUE = 3'h1;
   localparam logic [2:0] MODE_SPEED  = 3'h2;

   localparam word_t CMD_WORD_RESET = 16'h0000;
   localparam word_t PTR_RESET      = 16'h0000;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic  valid;
      logic  write;
      idx_t  idx;
      word_t data;
   } cyc_req_t;

   typedef struct packed {
      logic  valid;
      logic  write;
      logic  from_net;
      pnum_t num;
      word_t data;
   } cfg_req_t;

   typedef struct packed {
      logic  valid;
      logic  write;
      pnum_t num;
      word_t data;
   } ps_req_t;

   typedef struct packed {
      logic enabled;
      logic stopping;
      logic reverse;
      logic reached;
      logic fault;
   } drive_stat_t;

endpackage

// ==== core/map_pointer_bank.sv ====
// Read and write word pointer store with one write and two read ports
`timescale 1ns/1ps
`default_nettype none

module map_pointer_bank
   import fieldbus_io_pkg::*;
#(
   parameter int NSLOT = MAP_SLOTS
)
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic en_i,
   input  wire logic wr_en_i,
   input  wire logic wr_bank_i,
   input  wire idx_t wr_slot_i,
   input  wire word_t wr_data_i,
   input  wire logic cyc_bank_i,
   input  wire idx_t cyc_slot_i,
   output word_t     cyc_ptr_o,
   input  wire logic cfg_bank_i,
   input  wire idx_t cfg_slot_i,
   output word_t     cfg_ptr_o
);

   word_t ptr_q [2][NSLOT];

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int b = 0; b < 2; b++)
         begin
            for (int s = 0; s < NSLOT; s++)
            begin
               ptr_q[b][s] <= PTR_RESET;
            end
         end
      end
      else if (en_i && wr_en_i && (int'(wr_slot_i) < NSLOT))
      begin
         ptr_q[wr_bank_i][wr_slot_i] <= wr_data_i;
      end
   end

   // ----------------------------------------
   // Lookup
   // ----------------------------------------
   always_comb
   begin
      cyc_ptr_o = (int'(cyc_slot_i) < NSLOT) ? ptr_q[cyc_bank_i][cyc_slot_i] : PTR_RESET;
      cfg_ptr_o = (int'(cfg_slot_i) < NSLOT) ? ptr_q[cfg_bank_i][cfg_slot_i] : PTR_RESET;
   end

endmodule
`default_nettype wire

// ==== core/fieldbus_io_word_map.sv ====
// Fieldbus cyclic word map, command word and drive state word
//
// Summary of operation
// - Input words 3-14 return the parameter named by their read pointer.
// - Every mapped value moves as one 16-bit integer, decimals dropped.
// - Pointers act only while the I/O size option is 3 to 15.
// - At most 14 input words are presented, per the size option.
// - Zero pointer disables the transfer; the word count stays unchanged.
// - Output words 3-14 write the parameter named by their write pointer.
// - Fourteen output words exist while a programmable size option is active.
// - Output words 1 and 2 are fixed and never remapped.
// - Only fieldbus may write the command word; keypad writes are refused.
// - Command word acts only while the network is the command source, except its mode bits, which route word 2 from any source.
// - Command bit 0 enables the drive, cleared disables it.
// - Command bit 1 set requests stop; cleared requests none.
// - Command bit 7 clears an active fault, otherwise no effect.
// - State bit 0 is one while the drive is enabled.
// - State bit 1 is one while stopping.
// - State bit 6 is one once the reference is reached.
// - State bit 7 is one while the drive has a fault.
// - Mode bits 8-10 pick speed or current for word 2.
`timescale 1ns/1ps
`default_nettype none

module fieldbus_io_word_map
   import fieldbus_io_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        en_i,
   input  wire idx_t        io_size_i,
   input  wire logic        net_ctrl_sel_i,
   input  wire cyc_req_t    cyc_req_i,
   output logic             cyc_ready_o,
   output logic             cyc_ack_o,
   output word_t            cyc_rdata_o,
   output idx_t             in_count_o,
   output idx_t             out_count_o,
   input  wire cfg_req_t    cfg_req_i,
   output logic             cfg_ack_o,
   output logic             cfg_err_o,
   output word_t            cfg_rdata_o,
   output ps_req_t          ps_req_o,
   input  wire logic        ps_ack_i,
   input  wire word_t       ps_rdata_i,
   input  wire drive_stat_t stat_i,
   input  wire word_t       speed_act_i,
   input  wire word_t       current_act_i,
   output logic             drive_enable_o,
   output logic             stop_req_o,
   output logic             dir_rev_o,
   output logic             drive_reset_o,
   output logic             fault_clear_o,
   output logic [2:0]       op_mode_o,
   output word_t            speed_ref_o,
   output word_t            current_ref_o
);

   typedef enum logic [1:0] {IDLE, READ_WAIT, WRITE_WAIT} state_t;

   logic [1:0] rst_sync_q;
   logic       rst_n;
   state_t     state_q;
   word_t      cmd_q;
   word_t      state_word_q;
   logic       mapped_on;
   logic       cyc_take;
   logic       cyc_is_map;
   idx_t       cyc_slot;
   word_t      cyc_ptr;
   logic       cfg_rd_map;
   logic       cfg_wr_map;
   idx_t       cfg_slot;
   pnum_t      cfg_off;
   word_t      cfg_ptr;
   logic       ptr_wr;
   logic       cmd_from_cyc;
   logic       cmd_from_cfg;
   logic       cmd_wr;
   word_t      cmd_new;
   logic [2:0] mode;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_sync_q <= 2'b00;
      end
      else if (en_i)
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   always_comb
   begin
      mapped_on   = (io_size_i >= IO_SIZE_MIN) && (io_size_i <= IO_SIZE_MAX);
      in_count_o  = mapped_on ? idx_t'(io_size_i - 4'h1) : 4'h0;
      out_count_o = mapped_on ? MAX_WORDS : 4'h0;
      cyc_ready_o = (state_q == IDLE);
      cyc_take    = cyc_req_i.valid && cyc_ready_o;
      cyc_is_map  = (cyc_req_i.idx >= WORD_MAP_MIN) && (cyc_req_i.idx <= WORD_MAP_MAX);
      cyc_slot    = idx_t'(cyc_req_i.idx - WORD_MAP_MIN);
      cfg_rd_map  = (cfg_req_i.num >= RD_MAP_FIRST) && (cfg_req_i.num < WR_MAP_FIRST);
      cfg_wr_map  = (cfg_req_i.num >= WR_MAP_FIRST) && (cfg_req_i.num < CMD_WORD_NUM);
      cfg_off     = cfg_wr_map ? pnum_t'(cfg_req_i.num - WR_MAP_FIRST)
                               : pnum_t'(cfg_req_i.num - RD_MAP_FIRST);
      cfg_slot    = cfg_off[IDX_W-1:0];
      ptr_wr      = cfg_req_i.valid && cfg_req_i.write && (cfg_rd_map || cfg_wr_map)
                    && (cfg_req_i.data <= PTR_MAX);
      cmd_from_cyc = cyc_take && cyc_req_i.write && (cyc_req_i.idx == WORD_CMD);
      cmd_from_cfg = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.from_net
                     && (cfg_req_i.num == CMD_WORD_NUM);
      cmd_wr      = cmd_from_cyc || cmd_from_cfg;
      cmd_new     = cmd_from_cyc ? cyc_req_i.data : cfg_req_i.data;
      mode        = cmd_q[MODE_MSB:MODE_LSB];
   end

   map_pointer_bank #(
      .NSLOT (MAP_SLOTS)
   ) u_ptr (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n),
      .en_i       (en_i),
      .wr_en_i    (ptr_wr),
      .wr_bank_i  (cfg_wr_map),
      .wr_slot_i  (cfg_slot),
      .wr_data_i  (cfg_req_i.data),
      .cyc_bank_i (cyc_req_i.write),
      .cyc_slot_i (cyc_slot),
      .cyc_ptr_o  (cyc_ptr),
      .cfg_bank_i (cfg_wr_map),
      .cfg_slot_i (cfg_slot),
      .cfg_ptr_o  (cfg_ptr)
   );

   // ----------------------------------------
   // Parameter access port
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_ack_o   <= 1'b0;
         cfg_err_o   <= 1'b0;
         cfg_rdata_o <= 16'h0000;
      end
      else if (en_i)
      begin
         cfg_ack_o <= cfg_req_i.valid;
         cfg_err_o <= 1'b0;
         if (cfg_req_i.valid)
         begin
            cfg_rdata_o <= 16'h0000;
            cfg_err_o   <= 1'b1;
            if (cfg_rd_map || cfg_wr_map)
            begin
               cfg_rdata_o <= cfg_ptr;
               cfg_err_o   <= cfg_req_i.write && (cfg_req_i.data > PTR_MAX);
            end
            else if (cfg_req_i.num == CMD_WORD_NUM)
            begin
               cfg_rdata_o <= cmd_q;
               cfg_err_o   <= cfg_req_i.write && !cfg_req_i.from_net;
            end
            else if (cfg_req_i.num == STATE_WORD_NUM)
            begin
               cfg_rdata_o <= state_word_q;
               cfg_err_o   <= cfg_req_i.write;
            end
         end
      end
   end

   // ----------------------------------------
   // Command word
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_q <= CMD_WORD_RESET;
      end
      else if (en_i && cmd_wr)
      begin
         cmd_q <= cmd_new;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drive_enable_o <= 1'b0;
         stop_req_o     <= 1'b0;
         dir_rev_o      <= 1'b0;
         op_mode_o      <= 3'h0;
         drive_reset_o  <= 1'b0;
         fault_clear_o  <= 1'b0;
      end
      else if (en_i)
      begin
         drive_enable_o <= net_ctrl_sel_i && cmd_q[CW_ENABLE_BIT];
         stop_req_o     <= net_ctrl_sel_i && cmd_q[CW_STOP_BIT];
         if (net_ctrl_sel_i)
         begin
            dir_rev_o <= cmd_q[CW_DIR_BIT];
            op_mode_o <= mode;
         end
         drive_reset_o <= net_ctrl_sel_i && cmd_wr && cmd_new[CW_DRV_RESET_BIT];
         fault_clear_o <= net_ctrl_sel_i && cmd_wr && cmd_new[CW_FLT_RESET_BIT]
                          && stat_i.fault;
      end
   end

   // ----------------------------------------
   // Drive state word
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_word_q <= 16'h0000;
      end
      else if (en_i)
      begin
         state_word_q                   <= 16'h0000;
         state_word_q[CW_ENABLE_BIT]    <= stat_i.enabled;
         state_word_q[CW_STOP_BIT]      <= stat_i.stopping;
         state_word_q[CW_DIR_BIT]       <= stat_i.reverse;
         state_word_q[SW_REACHED_BIT]   <= stat_i.reached;
         state_word_q[SW_FAULT_BIT]     <= stat_i.fault;
         state_word_q[MODE_MSB:MODE_LSB] <= mode;
      end
   end

   // ----------------------------------------
   // Mode-dependent reference, output word 2
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         speed_ref_o   <= 16'h0000;
         current_ref_o <= 16'h0000;
      end
      else if (en_i && cyc_take && cyc_req_i.write && (cyc_req_i.idx == WORD_REF))
      begin
         if (mode == MODE_TORQUE)
         begin
            current_ref_o <= cyc_req_i.data;
         end
         else if (mode == MODE_SPEED)
         begin
            speed_ref_o <= cyc_req_i.data;
         end
      end
   end

   // ----------------------------------------
   // Cyclic exchange sequencer
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q     <= IDLE;
         ps_req_o    <= '0;
         cyc_ack_o   <= 1'b0;
         cyc_rdata_o <= 16'h0000;
      end
      else if (en_i)
      begin
         cyc_ack_o <= 1'b0;
         unique case (state_q)
            IDLE:
            begin
               if (cyc_take)
               begin
                  if (cyc_is_map && mapped_on && (cyc_ptr != 16'h0000)
                      && (cyc_req_i.write || (cyc_req_i.idx <= in_count_o)))
                  begin
                     ps_req_o.valid <= 1'b1;
                     ps_req_o.write <= cyc_req_i.write;
                     ps_req_o.num   <= cyc_ptr[PNUM_W-1:0];
                     ps_req_o.data  <= cyc_req_i.data;
                     state_q        <= cyc_req_i.write ? WRITE_WAIT : READ_WAIT;
                  end
                  else
                  begin
                     cyc_ack_o   <= 1'b1;
                     cyc_rdata_o <= 16'h0000;
                     if (!cyc_req_i.write && (cyc_req_i.idx == WORD_CMD))
                     begin
                        cyc_rdata_o <= state_word_q;
                     end
                     else if (!cyc_req_i.write && (cyc_req_i.idx == WORD_REF))
                     begin
                        cyc_rdata_o <= (mode == MODE_TORQUE) ? current_act_i : speed_act_i;
                     end
                  end
               end
            end
            READ_WAIT, WRITE_WAIT:
            begin
               if (ps_ack_i)
               begin
                  ps_req_o.valid <= 1'b0;
                  cyc_ack_o      <= 1'b1;
                  cyc_rdata_o    <= (state_q == READ_WAIT) ? ps_rdata_i : 16'h0000;
                  state_q        <= IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n || !en_i);

   keypad_refused_a: assert property (cfg_req_i.valid && cfg_req_i.write && !cfg_req_i.from_net
      && cfg_req_i.num == CMD_WORD_NUM && !cmd_from_cyc |=> $stable(cmd_q) && cfg_err_o)
      else $error("keypad write changed the command word");
   enable_follow_a: assert property (cmd_q[CW_ENABLE_BIT] && net_ctrl_sel_i |=> drive_enable_o)
      else $error("drive enable did not follow command bit");
   source_gate_a: assert property (!net_ctrl_sel_i |=> !drive_enable_o && !stop_req_o && !drive_reset_o)
      else $error("command acted without network source");
   stop_cmd_a: assert property (stop_req_o |-> $past(cmd_q[CW_STOP_BIT]))
      else $error("stop requested without command bit");
   fault_clear_a: assert property (fault_clear_o |-> $past(stat_i.fault) && $past(cmd_new[CW_FLT_RESET_BIT]))
      else $error("fault clear without active fault");
   state_fault_a: assert property (stat_i.fault && stat_i.enabled |=> state_word_q[SW_FAULT_BIT]
      && state_word_q[CW_ENABLE_BIT])
      else $error("state word missed fault or enable");
   zero_pointer_a: assert property (ps_req_o.valid |-> ps_req_o.num != 11'h000)
      else $error("parameter access issued through zero pointer");
   unmapped_idle_a: assert property (cyc_take && !mapped_on |=> state_q == IDLE && cyc_ack_o)
      else $error("pointer used outside programmable size");
   fixed_words_a: assert property (cyc_take && cyc_req_i.idx <= WORD_REF |=> !ps_req_o.valid ##0 cyc_ack_o)
      else $error("fixed word routed through a pointer");
   in_count_a: assert property (in_count_o <= MAX_WORDS)
      else $error("too many input words");
   read_answer_a: assert property (state_q == READ_WAIT && ps_ack_i |=> cyc_ack_o
      && cyc_rdata_o == $past(ps_rdata_i))
      else $error("mapped read answer wrong");

   mapped_read_c:  cover property (state_q == READ_WAIT ##[1:8] cyc_ack_o);
   mapped_write_c: cover property (state_q == WRITE_WAIT ##[1:8] cyc_ack_o);
   fault_clear_c:  cover property (fault_clear_o);
   keypad_c:       cover property (cfg_ack_o && cfg_err_o);

endmodule
`default_nettype wire

// ==== dv/param_store_model.sv ====
// Behavioural drive parameter store answering the word map
`timescale 1ns/1ps
`default_nettype none

module param_store_model
   import fieldbus_io_pkg::*;
(
   input  wire logic       clk_i,
   input  wire ps_req_t    req_i,
   input  wire logic [1:0] delay_i,
   output logic            ack_o,
   output word_t           rdata_o
);
   // ----------------------------------------
   // Store and answer timing
   // ----------------------------------------
   word_t      mem [0:2047];
   word_t      rdata_q;
   logic [1:0] cnt_q;
   int         n_acc;

   initial
   begin
      foreach (mem[i]) mem[i] = 16'h0000;
      ack_o = 1'b0;
      cnt_q = 2'h0;
      rdata_q = 16'h0000;
      n_acc = 0;
   end

   // Inverse of last value outside the answer cycle
   assign rdata_o = ack_o ? rdata_q : ~rdata_q;

   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      if (req_i.valid && !ack_o)
      begin
         if (cnt_q >= delay_i)
         begin
            ack_o <= 1'b1;
            cnt_q <= 2'h0;
            n_acc <= n_acc + 1;
            rdata_q <= mem[req_i.num];
            if (req_i.write) mem[req_i.num] <= req_i.data;
         end
         else
            cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== dv/test_fieldbus_io_word_map.sv ====
// Self-checking bench for the fieldbus cyclic word map
`timescale 1ns/1ps
`default_nettype none

module test_fieldbus_io_word_map;
   import fieldbus_io_pkg::*;

   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        en_i = 1'b1;
   idx_t        io_size_i = 4'hf;
   logic        net_ctrl_sel_i = 1'b0;
   cyc_req_t    cyc_req_i = '0;
   cfg_req_t    cfg_req_i = '0;
   drive_stat_t stat_i = '0;
   word_t       speed_act_i = 16'h0000;
   word_t       current_act_i = 16'h0000;
   logic [1:0]  delay = 2'h0;
   logic        cyc_ready_o, cyc_ack_o, cfg_ack_o, cfg_err_o, ps_ack_i;
   logic        drive_enable_o, stop_req_o, dir_rev_o, drive_reset_o, fault_clear_o;
   word_t       cyc_rdata_o, cfg_rdata_o, ps_rdata_i, speed_ref_o, current_ref_o;
   idx_t        in_count_o, out_count_o;
   ps_req_t     ps_req_o;
   logic [2:0]  op_mode_o;
   int          failures = 0;
   int          n_compared = 0;
   int          n_rst = 0;
   int          n_clr = 0;

   fieldbus_io_word_map dut (.clk_i, .resetn_i, .en_i, .io_size_i, .net_ctrl_sel_i,
      .cyc_req_i, .cyc_ready_o, .cyc_ack_o, .cyc_rdata_o, .in_count_o, .out_count_o,
      .cfg_req_i, .cfg_ack_o, .cfg_err_o, .cfg_rdata_o, .ps_req_o, .ps_ack_i, .ps_rdata_i,
      .stat_i, .speed_act_i, .current_act_i, .drive_enable_o, .stop_req_o, .dir_rev_o,
      .drive_reset_o, .fault_clear_o, .op_mode_o, .speed_ref_o, .current_ref_o);

   param_store_model store (.clk_i, .req_i(ps_req_o), .delay_i(delay), .ack_o(ps_ack_i),
      .rdata_o(ps_rdata_i));

   always #5 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      if (drive_reset_o === 1'b1) n_rst++;
      if (fault_clear_o === 1'b1) n_clr++;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic word_t exp_state(input drive_stat_t s, input logic [2:0] m);
      return {5'h00, m, s.fault, s.reached, 3'h0, s.reverse, s.stopping, s.enabled};
   endfunction

   function automatic word_t exp_in(input int s);
      return (s >= 3) ? word_t'(s - 1) : 16'h0000;
   endfunction

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input word_t got, input word_t exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cfg(input logic wr, input logic net, input int num, input word_t d,
                      output word_t rd, output logic err);
      @(negedge clk_i);
      cfg_req_i = '{1'b1, wr, net, pnum_t'(num), d};
      @(negedge clk_i);
      rd = cfg_rdata_o;
      err = cfg_err_o;
      if (cfg_ack_o !== 1'b1) check(16'h0000, 16'h0001);
      cfg_req_i = '0;
   endtask

   task automatic setp(input int num, input int val);
      word_t rd;
      logic  err;
      cfg(1'b1, 1'b1, num, word_t'(val), rd, err);
   endtask

   task automatic cyc(input logic wr, input idx_t idx, input word_t d, output word_t rd);
      int n;
      @(negedge clk_i);
      cyc_req_i = '{1'b1, wr, idx, d};
      @(negedge clk_i);
      cyc_req_i = '0;
      n = 0;
      while (cyc_ack_o !== 1'b1)
      begin
         check(word_t'(cyc_ready_o), 16'h0000);
         n++;
         if (n > 20)
         begin
            failures++;
            finish_test();
         end
         @(negedge clk_i);
      end
      check(word_t'(cyc_ready_o), 16'h0001);
      rd = cyc_rdata_o;
   endtask

   task automatic settle();
      repeat (3) @(negedge clk_i);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      word_t      rd, d;
      logic       err;
      logic [2:0] m;
      int         w, p, c0, r0;
      void'($urandom(51));
      repeat (6) @(posedge clk_i);
      @(negedge clk_i) resetn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      for (int n = 711; n <= 735; n++)
      begin
         cfg(1'b0, 1'b1, n, 16'h0000, rd, err);
         check(rd, 16'h0000);
      end
      for (int s = 0; s < 16; s++)
      begin
         @(negedge clk_i) io_size_i = idx_t'(s);
         #1;
         check(word_t'(in_count_o), exp_in(s));
         check(word_t'(out_count_o), (s >= 3) ? 16'h000e : 16'h0000);
      end
      cfg(1'b1, 1'b1, 711, 16'd1250, rd, err);
      check(word_t'(err), 16'h0001);
      cfg(1'b1, 1'b1, 711, 16'd1249, rd, err);
      check(word_t'(err), 16'h0000);
      cfg(1'b1, 1'b1, 736, 16'h0001, rd, err);
      check(word_t'(err), 16'h0001);
      for (int k = 0; k < 10; k++)
      begin
         w = 3 + $urandom % 12;
         p = 1 + $urandom % 700;
         d = word_t'($urandom);
         delay = 2'($urandom);
         store.mem[p] = d;
         setp(708 + w, p);
         cyc(1'b0, idx_t'(w), 16'h0000, rd);
         check(rd, d);
         setp(720 + w, p);
         cyc(1'b1, idx_t'(w), ~d, rd);
         check(store.mem[p], ~d);
      end
      setp(713, 0);
      setp(725, 0);
      c0 = store.n_acc;
      cyc(1'b0, 4'h5, 16'h0000, rd);
      check(rd, 16'h0000);
      cyc(1'b1, 4'h5, 16'h1234, rd);
      check(word_t'(store.n_acc - c0), 16'h0000);
      setp(711, 9);
      setp(723, 9);
      store.mem[9] = 16'h5a5a;
      @(negedge clk_i) io_size_i = 4'h3;
      cyc(1'b0, 4'h3, 16'h0000, rd);
      check(rd, 16'h0000);
      @(negedge clk_i) io_size_i = 4'h2;
      cyc(1'b0, 4'h3, 16'h0000, rd);
      check(rd, 16'h0000);
      cyc(1'b1, 4'h3, 16'h0bad, rd);
      check(store.mem[9], 16'h5a5a);
      @(negedge clk_i) io_size_i = 4'hf;
      cyc(1'b1, 4'h1, 16'h0001, rd);
      settle();
      check(word_t'(drive_enable_o), 16'h0000);
      @(negedge clk_i) net_ctrl_sel_i = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         m = i ? MODE_SPEED : MODE_TORQUE;
         speed_act_i = word_t'($urandom);
         current_act_i = word_t'($urandom);
         cyc(1'b1, 4'h1, word_t'({m, 8'h00}) | (i ? 16'h0005 : 16'h0003), rd);
         settle();
         check(word_t'(drive_enable_o), 16'h0001);
         check(word_t'(stop_req_o), word_t'(i == 0));
         check(word_t'(dir_rev_o), word_t'(i));
         check(word_t'(op_mode_o), word_t'(m));
         d = word_t'($urandom);
         cyc(1'b1, 4'h2, d, rd);
         settle();
         check(i ? speed_ref_o : current_ref_o, d);
         cyc(1'b0, 4'h2, 16'h0000, rd);
         check(rd, i ? speed_act_i : current_act_i);
      end
      cyc(1'b1, 4'h1, 16'h0000, rd);
      settle();
      check(word_t'(drive_enable_o), 16'h0000);
      cfg(1'b1, 1'b0, 735, 16'h0001, rd, err);
      check(word_t'(err), 16'h0001);
      cfg(1'b0, 1'b1, 735, 16'h0000, rd, err);
      check(rd, 16'h0000);
      c0 = n_clr;
      r0 = n_rst;
      cyc(1'b1, 4'h1, 16'h0080, rd);
      settle();
      check(word_t'(n_clr - c0), 16'h0000);
      @(negedge clk_i) stat_i.fault = 1'b1;
      cyc(1'b1, 4'h1, 16'h0080, rd);
      settle();
      check(word_t'(n_clr - c0), 16'h0001);
      cyc(1'b1, 4'h1, 16'h0040, rd);
      cyc(1'b1, 4'h1, 16'h0200, rd);
      settle();
      check(word_t'(n_rst - r0), 16'h0001);
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clk_i) stat_i = drive_stat_t'($urandom);
         cyc(1'b0, 4'h1, 16'h0000, rd);
         check(rd, exp_state(stat_i, MODE_SPEED));
      end
      // Clock enable low: a pointer write must be ignored
      @(negedge clk_i) en_i = 1'b0;
      cfg_req_i = '{1'b1, 1'b1, 1'b1, pnum_t'(711), 16'h0077};
      @(negedge clk_i) cfg_req_i = '0;
      check(word_t'(cfg_ack_o), 16'h0000);
      en_i = 1'b1;
      cfg(1'b0, 1'b1, 711, 16'h0000, rd, err);
      check(rd, 16'h0009);
      finish_test();
   end
endmodule
`default_nettype wire
